// file: core/lsf_pkg.sv
// Package with register map, field positions and constants of the limit status bank.
package lsf_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_INT_TEMP = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h2c;
	localparam logic [ADDR_W-1:0] OFF_CHAN_CFG = 8'h30;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] TEMP_RST = 8'h00;
	localparam int BIT_REMOTE_ONE = 0;
	localparam int BIT_REMOTE_TWO = 1;
	localparam int BIT_STANDBY = 2;
	localparam int BIT_MAIN = 3;
	localparam int BIT_FIVE = 4;
	localparam int BIT_CORE = 5;
	localparam int NUM_CH = 6;
	localparam int IRQ_W = 2;
	localparam int IRQ_UPDATE = 0;
	localparam int IRQ_ALARM = 1;
	localparam logic [7:0] ALARM_HYST = 8'h05;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		LSF_AL_IDLE = 2'b00,
		LSF_AL_ENGAGED = 2'b01
	} lsf_alarm_t;
endpackage

// file: core/lsf_bank.sv
// Limit status flag register bank with an AXI4-Lite slave.
// Overview of operation
// R1: Internal temperature reads as an 8-bit read-only value in bits 7 to 0.
// R2: Bit 0 shows remote diode one out of limits last conversion.
// R3: Bit 0 set once when remote diode one engages thermal alarm mode.
// R4: Bit 0 set once when remote diode one drops 5 degrees below alarm limit.
// R5: Bit 1 shows remote diode two, or analog input nine, out of limits.
// R6: Bit 1 set once when remote diode two engages thermal alarm mode.
// R7: Bit 1 set once when remote diode two drops 5 degrees below alarm limit.
// R8: Bit 2 shows standby supply rail out of limits.
// R9: Bit 3 shows main rail out of limits.
// R10: Bit 4 shows five volt rail out of limits.
// R11: Bit 5 shows processor core rail out of limits.
// R12: Status and temperature update once at each conversion cycle end.
// R13: Software writes to temperature and status registers are ignored.
`timescale 1ns/1ps
module lsf_bank (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic conv_done,
	input wire logic [7:0] int_temp_in,
	input wire logic [7:0] remote_one_temp,
	input wire logic [7:0] remote_one_high,
	input wire logic [7:0] remote_one_low,
	input wire logic [7:0] remote_one_alarm_lim,
	input wire logic [7:0] remote_two_temp,
	input wire logic [7:0] remote_two_high,
	input wire logic [7:0] remote_two_low,
	input wire logic [7:0] remote_two_alarm_lim,
	input wire logic [7:0] analog_input_nine,
	input wire logic [7:0] standby_supply_rail,
	input wire logic [7:0] standby_high,
	input wire logic [7:0] standby_low,
	input wire logic [7:0] main_rail,
	input wire logic [7:0] main_high,
	input wire logic [7:0] main_low,
	input wire logic [7:0] five_rail,
	input wire logic [7:0] five_high,
	input wire logic [7:0] five_low,
	input wire logic [7:0] processor_core_rail,
	input wire logic [7:0] core_high,
	input wire logic [7:0] core_low,
	input wire logic [lsf_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [lsf_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [lsf_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [lsf_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic thermal_alarm_mode_one,
	output logic thermal_alarm_mode_two,
	output logic irq
);
	import lsf_pkg::*;

	// Unsigned window compare of a reading against its high and low limits.
	function automatic logic out_of_lim(input logic [7:0] v, input logic [7:0] hi,
		input logic [7:0] lo);
		out_of_lim = (v > hi) || (v < lo);
	endfunction

	// Adds the hysteresis to the reading instead of taking it from the limit.
	// A limit below the hysteresis therefore never wraps into an early release.
	function automatic logic cooled(input logic [7:0] t, input logic [7:0] lim);
		cooled = ({1'b0, t} + {1'b0, ALARM_HYST}) <= {1'b0, lim};
	endfunction

	logic [7:0] status_r;
	logic [7:0] int_temp_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic two_is_voltage_r;
	lsf_alarm_t alarm_one_r;
	lsf_alarm_t alarm_two_r;
	logic [lsf_pkg::ADDR_W-1:0] awaddr_r;
	logic [lsf_pkg::DATA_W-1:0] wdata_r;
	logic [3:0] wstrb_r;
	logic aw_have_r;
	logic w_have_r;
	logic [NUM_CH-1:0] limit_hit;
	logic one_engage, one_release, two_engage, two_release;
	logic [7:0] two_value;
	logic wr_go;
	logic [IRQ_W-1:0] irq_set;

	// Limit compares, alarm transitions and interrupt events of this cycle.
	always_comb begin
		two_value = two_is_voltage_r ? analog_input_nine : remote_two_temp;
		limit_hit = '0;
		limit_hit[BIT_REMOTE_ONE] = out_of_lim(remote_one_temp, remote_one_high,
			remote_one_low); // R2
		limit_hit[BIT_REMOTE_TWO] = out_of_lim(two_value, remote_two_high,
			remote_two_low); // R5
		limit_hit[BIT_STANDBY] = out_of_lim(standby_supply_rail, standby_high, standby_low); // R8
		limit_hit[BIT_MAIN] = out_of_lim(main_rail, main_high, main_low); // R9
		limit_hit[BIT_FIVE] = out_of_lim(five_rail, five_high, five_low); // R10
		limit_hit[BIT_CORE] = out_of_lim(processor_core_rail, core_high, core_low); // R11
		one_engage = (alarm_one_r == LSF_AL_IDLE) && (remote_one_temp > remote_one_alarm_lim);
		one_release = (alarm_one_r == LSF_AL_ENGAGED) &&
			cooled(remote_one_temp, remote_one_alarm_lim);
		two_engage = !two_is_voltage_r && (alarm_two_r == LSF_AL_IDLE) &&
			(remote_two_temp > remote_two_alarm_lim);
		two_release = (alarm_two_r == LSF_AL_ENGAGED) && (two_is_voltage_r ||
			cooled(remote_two_temp, remote_two_alarm_lim));
		irq_set = '0;
		irq_set[IRQ_UPDATE] = conv_done;
		irq_set[IRQ_ALARM] = conv_done && (one_engage || one_release || two_engage || two_release);
		wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
	end

	// Alarm mode of remote diode one.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			alarm_one_r <= LSF_AL_IDLE;
		end else if (conv_done && one_engage) begin
			alarm_one_r <= LSF_AL_ENGAGED;
		end else if (conv_done && one_release) begin
			alarm_one_r <= LSF_AL_IDLE;
		end
	end

	// Alarm mode of remote diode two.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			alarm_two_r <= LSF_AL_IDLE;
		end else if (conv_done && two_engage) begin
			alarm_two_r <= LSF_AL_ENGAGED;
		end else if (conv_done && two_release) begin
			alarm_two_r <= LSF_AL_IDLE;
		end
	end

	// Status and temperature capture at conversion end.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			status_r <= STATUS_RST;
			int_temp_r <= TEMP_RST;
		end else if (conv_done) begin // R12
			int_temp_r <= int_temp_in; // R1
			status_r <= {2'b00, limit_hit};
			if (one_engage) begin
				status_r[BIT_REMOTE_ONE] <= 1'b1; // R3
			end
			if (one_release) begin
				status_r[BIT_REMOTE_ONE] <= 1'b1; // R4
			end
			if (two_engage) begin
				status_r[BIT_REMOTE_TWO] <= 1'b1; // R6
			end
			if (two_release) begin
				status_r[BIT_REMOTE_TWO] <= 1'b1; // R7
			end
		end
	end

	// Alarm mode outputs, one cycle behind the alarm state.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			thermal_alarm_mode_one <= 1'b0;
			thermal_alarm_mode_two <= 1'b0;
		end else begin
			thermal_alarm_mode_one <= (alarm_one_r == LSF_AL_ENGAGED);
			thermal_alarm_mode_two <= (alarm_two_r == LSF_AL_ENGAGED);
		end
	end

	// Write address and data capture, in either order.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			aw_have_r <= 1'b0;
			awaddr_r <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_r <= 1'b1;
			awaddr_r <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_have_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			w_have_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_r <= 1'b1;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end else if (wr_go) begin
			w_have_r <= 1'b0;
		end
	end

	// Address and data readies stay low from a take until the response is done.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
		end
	end

	// Write response; status and temperature writes change nothing.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			if (awaddr_r == OFF_STATUS || awaddr_r == OFF_INT_TEMP ||
				awaddr_r == OFF_IRQ_STAT || awaddr_r == OFF_IRQ_MASK ||
				awaddr_r == OFF_CHAN_CFG) begin
				s_axi_bresp <= RESP_OKAY; // R13
			end else begin
				s_axi_bresp <= RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Configuration registers.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_mask_r <= '0;
			two_is_voltage_r <= 1'b0;
		end else if (wr_go && wstrb_r[0]) begin
			if (awaddr_r == OFF_IRQ_MASK) begin
				irq_mask_r <= wdata_r[IRQ_W-1:0];
			end else if (awaddr_r == OFF_CHAN_CFG) begin
				two_is_voltage_r <= wdata_r[0];
			end
		end
	end

	// Sticky interrupt status; a new event wins over a clear.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_stat_r <= '0;
		end else if (wr_go && wstrb_r[0] && awaddr_r == OFF_IRQ_STAT) begin
			irq_stat_r <= (irq_stat_r & ~wdata_r[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_r <= irq_stat_r | irq_set;
		end
	end

	// Level interrupt while any unmasked sticky bit is set.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// Read channel.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= '0;
			if (s_axi_araddr == OFF_STATUS) begin
				s_axi_rdata[7:0] <= status_r;
			end else if (s_axi_araddr == OFF_INT_TEMP) begin
				s_axi_rdata[7:0] <= int_temp_r; // R1
			end else if (s_axi_araddr == OFF_IRQ_STAT) begin
				s_axi_rdata[IRQ_W-1:0] <= irq_stat_r;
			end else if (s_axi_araddr == OFF_IRQ_MASK) begin
				s_axi_rdata[IRQ_W-1:0] <= irq_mask_r;
			end else if (s_axi_araddr == OFF_CHAN_CFG) begin
				s_axi_rdata[0] <= two_is_voltage_r;
			end else begin
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule // lsf_bank

// file: verif/lsf_assertions.sv
// Concurrent checks on the ports of the limit status bank.
`timescale 1ns/1ps
module lsf_assertions (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic conv_done,
	input wire logic [7:0] remote_one_temp,
	input wire logic [7:0] remote_one_alarm_lim,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [lsf_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic thermal_alarm_mode_one
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	aw_hold_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready high right after a take");
	b_due_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid)
		else $error("write response late");
	b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	r_due_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	r_stand_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	ar_back_a: assert property (s_axi_rvalid && s_axi_rready |-> ##[1:3] s_axi_arready)
		else $error("arready did not return");
	alarm_on_a: assert property (conv_done && remote_one_temp > remote_one_alarm_lim
		|-> ##[2:3] thermal_alarm_mode_one)
		else $error("alarm mode not engaged");
	alarm_off_a: assert property (conv_done
		&& {1'b0, remote_one_temp} + 9'h005 <= {1'b0, remote_one_alarm_lim}
		|-> ##[2:3] !thermal_alarm_mode_one)
		else $error("alarm mode not released");
	cover property (conv_done && thermal_alarm_mode_one);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule // lsf_assertions
bind lsf_bank lsf_assertions u_chk (.*);

// file: verif/testbench.sv
// Self-checking testbench of the limit status bank.
`timescale 1ns/1ps
module testbench;
	import lsf_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic conv_done = 1'b0;
	logic [159:0] rv = '0;
	logic [7:0] int_temp_in, remote_one_temp, remote_one_high, remote_one_low, remote_two_temp;
	logic [7:0] remote_two_high, remote_two_low, analog_input_nine, standby_supply_rail;
	logic [7:0] standby_high, standby_low, main_rail, main_high, main_low, five_rail;
	logic [7:0] five_high, five_low, processor_core_rail, core_high, core_low;
	logic [7:0] remote_one_alarm_lim = 8'h08, remote_two_alarm_lim = 8'h08;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, msk, w;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic thermal_alarm_mode_one, thermal_alarm_mode_two, irq;
	logic [31:0] seed = 32'h16028;
	logic [7:0] st, tmp, tv;
	logic [1:0] irqst = 2'b00;
	logic eng1 = 1'b0, eng2 = 1'b0;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int num_errors = 0;
	int checked = 0;
	assign {int_temp_in, remote_one_temp, remote_one_high, remote_one_low, remote_two_temp,
		remote_two_high, remote_two_low, analog_input_nine, standby_supply_rail, standby_high,
		standby_low, main_rail, main_high, main_low, five_rail, five_high, five_low,
		processor_core_rail, core_high, core_low} = rv;
	lsf_bank u_dut (.*);
	always #4 ref_clk = ~ref_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic oor(input logic [7:0] v, h, l);
		return v > h || v < l;
	endfunction
	function automatic logic alm(inout logic e, input logic [7:0] t, l);
		logic x;
		x = (!e && t > l) || (e && 9'(t) + 9'h005 <= 9'(l));
		e ^= x;
		return x;
	endfunction
	task automatic tally_and_finish;
		if (num_errors == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string n, input logic [33:0] e, g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		int n;
		rq.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'(rnd());
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
		s_axi_rready <= 1'b0;
		@(posedge ref_clk);
		if (n == 50) begin
			num_errors++;
			tally_and_finish;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		int n;
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'(rnd());
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
		@(posedge ref_clk);
		if (n == 50) begin
			num_errors++;
			tally_and_finish;
		end
	endtask
	task automatic conv(input logic m);
		logic e1, e2;
		rv <= {rnd(), rnd(), rnd(), rnd(), rnd()};
		remote_one_alarm_lim <= 8'(rnd());
		remote_two_alarm_lim <= 8'(rnd());
		conv_done <= 1'b1;
		@(posedge ref_clk);
		conv_done <= 1'b0;
		e1 = alm(eng1, remote_one_temp, remote_one_alarm_lim);
		e2 = m ? eng2 : alm(eng2, remote_two_temp, remote_two_alarm_lim);
		if (m) eng2 = 1'b0;
		tv = m ? analog_input_nine : remote_two_temp;
		st = {2'b00, oor(processor_core_rail, core_high, core_low), oor(five_rail, five_high,
			five_low), oor(main_rail, main_high, main_low), oor(standby_supply_rail,
			standby_high, standby_low), oor(tv, remote_two_high, remote_two_low) | e2,
			oor(remote_one_temp, remote_one_high, remote_one_low) | e1};
		tmp = int_temp_in;
		irqst |= {e1 | e2, 1'b1};
	endtask
	always @(posedge ref_clk) begin
		if (s_axi_rvalid && s_axi_rready) chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready) chk("bresp", 34'(bq.pop_front()), 34'(s_axi_bresp));
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rd(OFF_STATUS, 32'(STATUS_RST));
		rd(OFF_INT_TEMP, 32'(TEMP_RST));
		rd(8'h40, 32'h0, RESP_SLVERR);
		wr(8'h44, rnd(), RESP_SLVERR);
		for (int i = 0; i < 40; i++) begin
			wr(OFF_CHAN_CFG, 32'(i >= 20));
			msk = 2'(rnd());
			wr(OFF_IRQ_MASK, 32'(msk));
			conv(i >= 20);
			wr(OFF_STATUS, rnd());
			wr(OFF_INT_TEMP, rnd());
			rd(OFF_STATUS, 32'(st));
			rd(OFF_INT_TEMP, 32'(tmp));
			rd(OFF_IRQ_STAT, 32'(irqst));
			rd(OFF_IRQ_MASK, 32'(msk));
			chk("alarm_one", 34'(eng1), 34'(thermal_alarm_mode_one));
			chk("alarm_two", 34'(eng2), 34'(thermal_alarm_mode_two));
			w = 2'(rnd());
			wr(OFF_IRQ_STAT, 32'(w));
			irqst &= ~w;
			repeat (3) @(posedge ref_clk);
			chk("irq", 34'(|(irqst & msk)), 34'(irq));
		end
		tally_and_finish;
	end
endmodule // testbench
